// [verif/seal_monitor.sv]
// link checker for the two ends of the serial memory link.
// assumes link signals and the shared clock arrive as inputs.
`timescale 1ns/1ps
module seal_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link signals
    input wire logic cs_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic hold_n,
    input wire logic so_o,
    input wire logic so_oe_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // serial clock rests low outside frames
    a_sck_idle_low: assert property (cs_n |-> !sck)
        else $error("sck high while deselected");
    a_sck_high_len: assert property ($rose(sck) |-> sck[*8] ##1 !sck)
        else $error("sck high phase not 8 cycles");
    a_mosi_steady: assert property (sck && $past(sck) |-> $stable(mosi))
        else $error("mosi moved while sck high");
    a_select_low: assert property ($fell(cs_n) |-> !sck)
        else $error("select fell with sck high");
    a_drive_selected: assert property ($fell(so_oe_n) |-> !cs_n && hold_n)
        else $error("so driven while not selected");
    a_release_desel: assert property ($rose(cs_n) |-> ##[1:6] so_oe_n)
        else $error("so not released after deselect");
    a_float_pause: assert property ((!hold_n)[*6] |-> so_oe_n)
        else $error("so driven during pause");
    // a late data change while sck high would break mode 0 sampling
    a_so_change_low: assert property (
        $changed(so_o) && !so_oe_n && !$past(so_oe_n) |-> !sck)
        else $error("so changed while sck high");

    // main scenarios reached
    c_read_out: cover property ($fell(so_oe_n));
    c_pause: cover property ((!hold_n)[*6]);
    c_frame_end: cover property ($rose(cs_n));
endmodule // seal_monitor

// [verif/tb_top.sv]
// bench joining both ends; a small array model predicts read bytes.
// assumes the program cycle parameter is shortened to 200 cycles.
`timescale 1ns/1ps
module tb_top;
    import seal_pkg::*;
    logic clk = 0, rst_n = 0, cmd_valid = 0, tx_valid = 0, rx_ready = 0;
    logic pause = 0, wp_level = 1, cmd_ready, done, tx_ready, rx_valid, busy;
    logic [7:0] cmd_op = 8'h00, tx_data = 8'h00, rx_data, status;
    logic [15:0] cmd_addr = 16'h0000;
    logic [LEN_W-1:0] cmd_len = '0;
    logic [10:0] k = '0;
    logic [7:0] mem [int];
    logic [7:0] expq [$];
    logic [7:0] txq [$];
    int errors = 0, n_compared = 0;

    seal_link_if seal_link_if_i ();
    seal_device #(.WRITE_CYCLE_CYCLES(200)) seal_device_i (.clk(clk),
        .rst_n(rst_n), .ce(1'b1), .link(seal_link_if_i.dev), .busy(busy),
        .status(status));
    seal_host seal_host_i (.clk(clk), .rst_n(rst_n), .ce(1'b1),
        .link(seal_link_if_i.host), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_len(cmd_len), .done(done), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_data(rx_data), .pause(pause),
        .wp_level(wp_level));
    seal_monitor seal_monitor_i (.clk(clk), .rst_n(rst_n),
        .cs_n(seal_link_if_i.cs_n), .sck(seal_link_if_i.sck),
        .mosi(seal_link_if_i.mosi), .hold_n(seal_link_if_i.hold_n),
        .so_o(seal_link_if_i.so_o), .so_oe_n(seal_link_if_i.so_oe_n));

    always #25 clk = ~clk;

    // long reader stalls fill the read buffer; pauses come now and then
    always @(posedge clk) begin
        #1 k = k + 1;
        rx_ready = k[8];
        pause = k[10:8] == 3'd5;
    end

    // read bytes are checked against the oldest prediction
    always @(posedge clk)
        if (rx_valid && rx_ready)
            chk(rx_data, expq.pop_front());

    task automatic chk(logic [7:0] s, logic [7:0] e);
        n_compared++;
        if (s !== e) begin
            errors++;
            $display("wrong value at %0t: %h, expected %h", $time, s, e);
        end
    endtask

    task automatic wrap_up;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // one frame; write bytes come from txq
    task automatic cmd(logic [7:0] op, logic [15:0] a, int n);
        @(posedge clk) #1;
        cmd_op = op;
        cmd_addr = a;
        cmd_len = n[LEN_W-1:0];
        cmd_valid = 1;
        @(posedge clk iff cmd_ready);
        #1 cmd_valid = 0;
        while (!done) begin
            tx_valid = txq.size() > 0;
            if (tx_valid)
                tx_data = txq[0];
            @(posedge clk);
            if (tx_valid && tx_ready)
                void'(txq.pop_front());
            #1;
        end
        tx_valid = 0;
    endtask

    // page write; land says whether the model takes the bytes
    task automatic wr(logic [15:0] a, int n, bit lat, bit land,
                      logic [7:0] st);
        logic [7:0] b;
        if (lat)
            cmd(SET_WRITE_LATCH_CMD, 16'h0000, 0);
        for (int i = 0; i < n; i++) begin
            b = 8'($urandom);
            txq.push_back(b);
            if (land)
                mem[int'({a[10:5], i[4:0]})] = b;
        end
        cmd(ARRAY_WRITE_CMD, a, n);
        repeat (6) @(posedge clk);
        chk(status, land ? STATUS_BUSY_VAL : st);
        chk(8'(busy), 8'(land));
        expq.push_back(land ? STATUS_BUSY_VAL : st);
        cmd(STATUS_READ_CMD, 16'h0000, 1);
        repeat (300) @(posedge clk);
        chk(status, st);
    endtask

    task automatic stw(logic [7:0] v, logic [7:0] st);
        cmd(SET_WRITE_LATCH_CMD, 16'h0000, 0);
        txq.push_back(v);
        cmd(STATUS_WRITE_CMD, 16'h0000, 1);
        repeat (300) @(posedge clk);
        chk(status, st);
    endtask

    task automatic rd(logic [15:0] a, int n);
        for (int i = 0; i < n; i++)
            expq.push_back(mem[int'((a + i) & 16'h07ff)]);
        cmd(ARRAY_READ_CMD, a, n);
        while (expq.size() > 0)
            @(posedge clk);
    endtask

    initial begin
        void'($urandom(26));
        repeat (5) @(posedge clk);
        #1 rst_n = 1;
        repeat (4) @(posedge clk);
        #1;
        wr(16'hf7e0, 34, 1, 1, 8'h00);
        wr(16'h0000, 2, 1, 1, 8'h00);
        rd(16'h07f0, 18);
        wr(16'h07e0, 3, 0, 0, 8'h00);
        stw(8'h84, 8'h84);
        wr(16'h07e0, 2, 1, 0, 8'h86);
        #1 wp_level = 0;
        stw(8'h00, 8'h86);
        cmd(CLR_WRITE_LATCH_CMD, 16'h0000, 0);
        chk(status, 8'h84);
        rd(16'h07e0, 4);
        wrap_up();
    end

    // hang guard, well above the expected run length
    initial begin
        repeat (90000) @(posedge clk);
        errors++;
        wrap_up();
    end
endmodule // tb_top

// [verilog/seal_device.sv]
// memory end of the serial link: command decode, array read and page
// write, status byte and write protection, self-timed program cycle.
// assumes link pins are asynchronous to clk and sck stays well below
// a quarter of the clk rate.
//
// Notes on behaviour
// R1: protect enable cannot clear while pin low
// R2: writes gated by latch, blocks, pin
// R3: read: opcode, 16-bit address, byte out MSB-first
// R4: serial input ignored for rest of read
// R5: read address increments, wraps to zero
// R6: host raises select after one byte to stop
// R7: write without latch discarded, standby on deselect
// R8: ignored write needs fresh select falling edge
// R9: writes only outside the protected range
// R10: busy cycle ignores all but status read
// R11: write programs only after select rises
// R12: host deselects in clock low after D0
// R13: status bit 0 is one while busy
// R14: page write increments five low address bits
// R15: over 32 bytes wrap within the page
// R16: program end clears the write latch
// R17: eleven address bits decoded, rest ignored
// R18: eight-bit opcodes MSB-first, bit 3 ignored
// R19: status all ones while busy, 4..6 zero
// R20: protect bits pick none, quarter, half, all
// R21: pause holds state, output floats, input ignored
// R22: mode 0: sample rising, change after falling
`timescale 1ns/1ps
module seal_device
    import seal_pkg::*;
#(
    parameter int WRITE_CYCLE_CYCLES = T_WC_CYCLES
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // serial link
    seal_link_if.dev link,
    // local view of the memory state
    output logic busy,
    output logic [7:0] status
);
    localparam int TW = $clog2(WRITE_CYCLE_CYCLES + 1);

    typedef struct packed {
        logic [1:0] cs_s;
        logic [1:0] sck_s;
        logic [1:0] si_s;
        logic [1:0] hold_s;
        logic [1:0] wp_s;
        logic sck_last;
        seal_dstate_type st;
        logic is_write;
        logic [3:0] bitc;
        logic [7:0] rx;
        logic [15:0] addr;
        logic [7:0] tx;
        logic so;
        logic so_oe_n;
        logic wel;
        logic hw_protect_enable_bit;
        logic block_protect_high;
        logic block_protect_low;
        logic [PAGE_BYTES-1:0] mask;
        logic sr_pend;
        logic [7:0] sr_val;
        logic busy;
        logic [TW-1:0] timer;
        logic commit;
        logic [PAGE_BITS-1:0] cidx;
        logic [7:0] status;
    } seal_dev_type;

    seal_dev_type q, d;
    logic [7:0] mem [MEM_WORDS];
    logic [7:0] page [PAGE_BYTES];
    logic [7:0] cur;
    logic [7:0] nr;
    logic [15:0] naddr;
    logic [10:0] rd_a;
    logic [7:0] rd_byte;
    logic rise;
    logic fall;
    logic pg_we;
    logic mem_we;
    logic [1:0] bp;
    logic wr_ok;

    // second synchroniser stages only; first stages feed nothing else
    assign rise = q.sck_s[1] && !q.sck_last;
    assign fall = !q.sck_s[1] && q.sck_last;
    assign nr = {q.rx[6:0], q.si_s[1]};
    assign naddr = {q.addr[14:0], q.si_s[1]};
    assign bp = {q.block_protect_high, q.block_protect_low};
    // status may change only while the latch is set and the pin allows
    assign wr_ok = !q.hw_protect_enable_bit || q.wp_s[1]; // R1 R2
    // address bits above the array are never looked at
    assign rd_a = (q.st == D_ADDR) ? naddr[10:0]
                                   : q.addr[10:0] + 11'h001; // R17 R5
    assign rd_byte = mem[rd_a];
    // busy status reads as all ones; spare bits are zero otherwise
    assign cur = q.busy ? STATUS_BUSY_VAL
               : {q.hw_protect_enable_bit, 3'b000, bp, q.wel, 1'b0}; // R19 R13

    // one step of the link engine and the program cycle
    always_comb begin
        d = q;
        pg_we = 1'b0;
        d.cs_s = {q.cs_s[0], link.cs_n};
        d.sck_s = {q.sck_s[0], link.sck};
        d.si_s = {q.si_s[0], link.mosi};
        d.hold_s = {q.hold_s[0], link.hold_n};
        d.wp_s = {q.wp_s[0], link.wp_n};
        d.sck_last = q.sck_s[1];
        d.status = cur;
        // program cycle counts down while the page walks into the array
        if (q.busy) begin
            d.timer = q.timer - 1'b1;
            if (q.timer == TW'(1)) begin
                d.busy = 1'b0;
                d.wel = 1'b0; // R16
            end
            if (q.commit) begin
                d.cidx = q.cidx + 1'b1;
                if (q.cidx == PAGE_BITS'(PAGE_BYTES - 1)) begin
                    d.commit = 1'b0;
                end
            end
        end
        if (q.cs_s[1]) begin
            // deselect ends the frame; programming starts only now
            if (q.st == D_WDATA && |q.mask
                && !seal_is_protected(bp, q.addr[10:0])) begin // R9 R11 R20
                d.busy = 1'b1;
                d.timer = TW'(WRITE_CYCLE_CYCLES);
                d.commit = 1'b1;
                d.cidx = '0;
            end
            if (q.st == D_SWR && q.sr_pend && wr_ok) begin // R1 R2
                d.hw_protect_enable_bit = q.sr_val[ST_HW_PROT];
                d.block_protect_high = q.sr_val[ST_BP_HI];
                d.block_protect_low = q.sr_val[ST_BP_LO];
                d.busy = 1'b1;
                d.timer = TW'(WRITE_CYCLE_CYCLES);
            end
            d.st = D_IDLE; // R7
            d.so_oe_n = 1'b1;
        end else if (!q.hold_s[1]) begin
            // paused: output released, clock edges skipped
            d.so_oe_n = 1'b1; // R21
        end else begin
            d.so_oe_n = !(q.st == D_RDATA || q.st == D_SRD);
            case (q.st)
                D_IDLE: begin
                    d.st = D_OPC;
                    d.bitc = '0;
                end
                D_OPC: begin
                    if (rise) begin
                        d.rx = nr; // R22
                        d.bitc = q.bitc + 1'b1;
                        if (q.bitc == 4'h7) begin // R18
                            d.bitc = '0;
                            d.st = D_IGNORE;
                            d.sr_pend = 1'b0;
                            if (q.busy) begin
                                if (seal_op_is(nr, STATUS_READ_CMD)) begin // R10
                                    d.st = D_SRD;
                                    d.tx = cur;
                                end
                            end else if (seal_op_is(nr, SET_WRITE_LATCH_CMD)) begin
                                d.wel = 1'b1;
                            end else if (seal_op_is(nr, CLR_WRITE_LATCH_CMD)) begin
                                d.wel = 1'b0;
                            end else if (seal_op_is(nr, STATUS_READ_CMD)) begin
                                d.st = D_SRD;
                                d.tx = cur;
                            end else if (seal_op_is(nr, STATUS_WRITE_CMD)) begin
                                d.st = q.wel ? D_SWR : D_IGNORE; // R2
                            end else if (seal_op_is(nr, ARRAY_READ_CMD)) begin
                                d.st = D_ADDR; // R3
                                d.is_write = 1'b0;
                            end else if (seal_op_is(nr, ARRAY_WRITE_CMD)) begin
                                // without the latch: ignore until deselect
                                d.st = q.wel ? D_ADDR : D_IGNORE; // R7 R8 R2
                                d.is_write = 1'b1;
                            end
                        end
                    end
                end
                D_ADDR: begin
                    if (rise) begin
                        d.addr = naddr; // R3
                        d.bitc = q.bitc + 1'b1;
                        if (q.bitc == 4'hf) begin
                            d.bitc = '0;
                            d.mask = '0;
                            d.st = q.is_write ? D_WDATA : D_RDATA;
                            d.tx = rd_byte;
                        end
                    end
                end
                D_WDATA: begin
                    if (rise) begin
                        d.rx = nr;
                        d.bitc = q.bitc + 1'b1;
                        if (q.bitc == 4'h7) begin
                            d.bitc = '0;
                            pg_we = 1'b1; // R15
                            d.mask[q.addr[4:0]] = 1'b1;
                            d.addr[4:0] = q.addr[4:0] + 5'h01; // R14
                        end
                    end
                end
                D_SWR: begin
                    if (rise) begin
                        d.rx = nr;
                        d.bitc = q.bitc + 1'b1;
                        if (q.bitc == 4'h7) begin
                            d.bitc = '0;
                            d.sr_val = nr;
                            d.sr_pend = 1'b1;
                        end
                    end
                end
                default: begin
                end
            endcase
            // output side: rising edges of a read carry nothing
            if (fall && (q.st == D_RDATA || q.st == D_SRD)) begin // R4
                d.so = q.tx[7]; // R22 R3
                d.tx = {q.tx[6:0], 1'b0};
                d.bitc = q.bitc + 1'b1;
                if (q.bitc == 4'h7) begin
                    d.bitc = '0;
                    if (q.st == D_RDATA) begin
                        d.addr[10:0] = rd_a; // R5
                        d.tx = rd_byte;
                    end else begin
                        d.tx = cur;
                    end
                end
            end
        end
    end

    // array write walks the page buffer, one byte a cycle
    assign mem_we = q.commit && q.mask[q.cidx];

    always_ff @(posedge clk) begin
        if (ce && pg_we) begin
            page[q.addr[4:0]] <= nr;
        end
        if (ce && mem_we) begin
            mem[{q.addr[10:5], q.cidx}] <= page[q.cidx];
        end
    end

    // nonvolatile bits come up cleared; the array keeps no reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
            q.st <= D_IDLE;
            q.cs_s <= 2'b11;
            q.hold_s <= 2'b11;
            q.wp_s <= 2'b11;
            q.so_oe_n <= 1'b1;
            q.status <= STATUS_RST;
        end else if (ce) begin
            q <= d;
        end
    end

    assign link.so_o = q.so;
    assign link.so_oe_n = q.so_oe_n;
    assign busy = q.busy;
    assign status = q.status;
endmodule // seal_device

// [verilog/seal_fifo2.sv]
// two-entry buffer with valid and ready on both sides.
// assumes one clock; all outputs come from flip-flops.
`timescale 1ns/1ps
module seal_fifo2 #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    typedef struct packed {
        logic v0;
        logic v1;
        logic [W-1:0] d0;
        logic [W-1:0] d1;
    } seal_fifo_type;

    seal_fifo_type q, d;

    // slot 0 is always the head, so the output needs no mux
    always_comb begin
        d = q;
        if (q.v0 && out_ready) begin
            d.d0 = q.d1;
            d.v0 = q.v1;
            d.v1 = 1'b0;
        end
        if (in_valid && !q.v1) begin
            if (!d.v0) begin
                d.d0 = in_data;
                d.v0 = 1'b1;
            end else begin
                d.d1 = in_data;
                d.v1 = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign in_ready = !q.v1;
    assign out_valid = q.v0;
    assign out_data = q.d0;
endmodule // seal_fifo2

// [verilog/seal_host.sv]
// controller end of the serial link: makes sck by division, shifts
// frames of opcode, address and data bytes, buffers read bytes.
// assumes the memory end sits on the shared link interface.
`timescale 1ns/1ps
module seal_host
    import seal_pkg::*;
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // serial link
    seal_link_if.host link,
    // command request
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [7:0] cmd_op,
    input wire logic [15:0] cmd_addr,
    input wire logic [LEN_W-1:0] cmd_len,
    output logic done,
    // write data stream
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_data,
    // read data stream
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [7:0] rx_data,
    // pins under local control
    input wire logic pause,
    input wire logic wp_level
);
    localparam logic [SCK_DIV_W-1:0] HALF_LAST =
        SCK_DIV_W'(SCK_HALF_CYCLES - 1);

    typedef struct packed {
        seal_hstate_type st;
        logic cs_n;
        logic sck;
        logic mosi;
        logic hold_n;
        logic wp_n;
        logic [1:0] miso_s;
        logic [SCK_DIV_W-1:0] div;
        logic [7:0] sh;
        logic [2:0] bitc;
        logic [1:0] hdr;
        logic [15:0] abuf;
        logic [LEN_W-1:0] left;
        logic rx_mode;
        logic wr_mode;
        logic data_byte;
        logic cmd_ready;
        logic tx_ready;
        logic done;
        logic push;
        logic [7:0] pdata;
    } seal_host_type;

    seal_host_type q, d;
    logic in_ready;
    logic [7:0] nb;

    assign nb = {q.sh[6:0], q.miso_s[1]};

    // frame sequencer; sck high halves last SCK_HALF_CYCLES clocks, low halves at least that
    always_comb begin
        d = q;
        d.miso_s = {q.miso_s[0], link.miso};
        d.wp_n = wp_level;
        d.done = 1'b0;
        d.push = 1'b0;
        d.div = q.div + 1'b1;
        case (q.st)
            H_IDLE: begin
                d.div = '0;
                if (cmd_valid && q.cmd_ready) begin
                    // a fresh select fall opens every frame
                    d.cmd_ready = 1'b0;
                    d.cs_n = 1'b0; // R8
                    d.sh = cmd_op; // R18
                    d.mosi = cmd_op[7];
                    d.abuf = cmd_addr;
                    d.left = cmd_len;
                    d.hdr = (seal_op_is(cmd_op, ARRAY_READ_CMD)
                             || seal_op_is(cmd_op, ARRAY_WRITE_CMD))
                            ? 2'd2 : 2'd0;
                    d.rx_mode = seal_op_is(cmd_op, ARRAY_READ_CMD)
                             || seal_op_is(cmd_op, STATUS_READ_CMD);
                    d.wr_mode = !d.rx_mode;
                    d.data_byte = 1'b0;
                    d.bitc = '0;
                    d.st = H_LOW;
                end
            end
            H_LOW: begin
                if (q.div == HALF_LAST) begin
                    d.div = '0;
                    d.sck = 1'b1;
                    d.st = H_HIGH;
                end
            end
            H_HIGH: begin
                if (q.div == HALF_LAST) begin
                    // sample just before the fall, change data at it
                    d.div = '0;
                    d.sck = 1'b0; // R22
                    d.sh = nb;
                    d.mosi = nb[7];
                    d.bitc = q.bitc + 1'b1;
                    d.st = H_LOW;
                    if (q.bitc == 3'h7) begin
                        d.push = q.data_byte && q.rx_mode;
                        d.pdata = nb;
                        d.st = H_NEXT;
                    end
                end
            end
            H_NEXT: begin
                d.div = '0;
                if (q.hdr != 2'd0) begin
                    d.sh = q.abuf[15:8];
                    d.mosi = q.abuf[15];
                    d.abuf = {q.abuf[7:0], 8'h00};
                    d.hdr = q.hdr - 1'b1;
                    d.st = H_LOW;
                end else if (q.left == '0) begin
                    // deselect in sck low right after the last bit
                    d.cs_n = 1'b1; // R12 R6 R11
                    d.st = H_DESEL;
                end else if (pause && !q.tx_ready) begin
                    d.hold_n = 1'b0; // R21
                    d.st = H_HOLD;
                end else if (q.wr_mode) begin
                    d.tx_ready = 1'b1;
                    if (q.tx_ready && tx_valid) begin
                        d.tx_ready = 1'b0;
                        d.sh = tx_data;
                        d.mosi = tx_data[7];
                        d.left = q.left - 1'b1;
                        d.data_byte = 1'b1;
                        d.st = H_LOW;
                    end
                end else if (in_ready && !q.push) begin
                    // wait for the last push to land; then need a free slot
                    d.sh = 8'h00;
                    d.mosi = 1'b0;
                    d.left = q.left - 1'b1;
                    d.data_byte = 1'b1;
                    d.st = H_LOW;
                end
            end
            H_HOLD: begin
                d.div = '0;
                if (!pause) begin
                    d.hold_n = 1'b1; // R21
                    d.st = H_NEXT;
                end
            end
            H_DESEL: begin
                if (q.div == HALF_LAST) begin
                    d.done = 1'b1;
                    d.cmd_ready = 1'b1;
                    d.st = H_IDLE;
                end
            end
            default: begin
                d.st = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
            q.st <= H_IDLE;
            q.cs_n <= 1'b1;
            q.hold_n <= 1'b1;
            q.wp_n <= 1'b1;
            q.cmd_ready <= 1'b1;
        end else if (ce) begin
            q <= d;
        end
    end

    // read bytes wait here while the user side stalls
    seal_fifo2 #(
        .W(8)
    ) u_rx_buf (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .in_valid(q.push),
        .in_ready(in_ready),
        .in_data(q.pdata),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_data)
    );

    assign link.cs_n = q.cs_n;
    assign link.sck = q.sck;
    assign link.mosi = q.mosi;
    assign link.hold_n = q.hold_n;
    assign link.wp_n = q.wp_n;
    assign cmd_ready = q.cmd_ready;
    assign tx_ready = q.tx_ready;
    assign done = q.done;
endmodule // seal_host

// [verilog/seal_link_if.sv]
// serial link between the memory end and the controller end.
// assumes both ends run on the same system clock; the released
// serial output line is resolved here and settles high.
`timescale 1ns/1ps
interface seal_link_if;
    logic cs_n;
    logic sck;
    logic mosi;
    logic hold_n;
    logic wp_n;
    logic so_o;
    logic so_oe_n;
    logic miso;

    // pulled high while the memory end releases its output
    assign miso = so_oe_n ? 1'b1 : so_o;

    modport dev (input cs_n, sck, mosi, hold_n, wp_n, output so_o, so_oe_n);
    modport host (output cs_n, sck, mosi, hold_n, wp_n, input miso);
endinterface

// [verilog/seal_pkg.sv]
// shared constants, opcodes, state codes and helpers of the serial
// memory access logic; both ends of the link import this package.
package seal_pkg;

    // clock rate and serial clock timing
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_PER_US = CLK_HZ / 1_000_000;
    localparam int SCK_HALF_NS = 400;
    // least time: rounded up to whole cycles
    localparam int SCK_HALF_CYCLES = (SCK_HALF_NS * CLK_PER_US + 999) / 1000;
    localparam int SCK_DIV_W = 4;
    // self-timed program cycle, longest time: rounded down
    localparam int T_WC_US = 5000;
    localparam int T_WC_CYCLES = T_WC_US * CLK_PER_US;

    // array geometry: larger variant decodes eleven address bits
    localparam int ADDR_BITS = 11;
    localparam int MEM_WORDS = 2048;
    localparam int PAGE_BITS = 5;
    localparam int PAGE_BYTES = 32;
    localparam int LEN_W = 12;

    // opcodes, compared after masking the ignored bit 3
    localparam logic [7:0] OPC_MASK = 8'hf7;
    localparam logic [7:0] SET_WRITE_LATCH_CMD = 8'h06;
    localparam logic [7:0] CLR_WRITE_LATCH_CMD = 8'h04;
    localparam logic [7:0] STATUS_READ_CMD = 8'h05;
    localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] ARRAY_READ_CMD = 8'h03;
    localparam logic [7:0] ARRAY_WRITE_CMD = 8'h02;

    // status byte layout and values
    localparam int ST_BUSY = 0;
    localparam int ST_WEL = 1;
    localparam int ST_BP_LO = 2;
    localparam int ST_BP_HI = 3;
    localparam int ST_HW_PROT = 7;
    localparam logic [7:0] STATUS_BUSY_VAL = 8'hff;
    localparam logic [7:0] STATUS_RST = 8'h00;

    // device states
    typedef enum logic [7:0] {
        D_IDLE = 8'h01, D_OPC = 8'h02, D_ADDR = 8'h04, D_RDATA = 8'h08,
        D_WDATA = 8'h10, D_SRD = 8'h20, D_SWR = 8'h40, D_IGNORE = 8'h80
    } seal_dstate_type;

    // host states
    typedef enum logic [5:0] {
        H_IDLE = 6'h01, H_LOW = 6'h02, H_HIGH = 6'h04, H_NEXT = 6'h08,
        H_HOLD = 6'h10, H_DESEL = 6'h20
    } seal_hstate_type;

    // opcode match with bit 3 ignored
    function automatic logic seal_op_is(input logic [7:0] rx,
                                        input logic [7:0] op);
        return (rx & OPC_MASK) == op;
    endfunction

    // block protect level against an array address
    function automatic logic seal_is_protected(input logic [1:0] bp,
                                               input logic [10:0] a);
        case (bp)
            2'b01: return a[10:9] == 2'b11;
            2'b10: return a[10];
            2'b11: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

endpackage
